// ---- rtl/wdt_pkg.sv ----
// Purpose: shared constants for the windowed watchdog with counter readback
// Assumes: byte-wide register port, 20 MHz system clock
// Notes: offsets are register indices on the plain port
package wdt_pkg;
   // ===================================================
   // register offsets
   localparam logic [2:0] OFS_CONTROL_ZERO = 3'h0;
   localparam logic [2:0] OFS_CONTROL_ONE = 3'h1;
   localparam logic [2:0] OFS_PRESCALE_LOW = 3'h2;
   localparam logic [2:0] OFS_PRESCALE_HIGH = 3'h3;
   localparam logic [2:0] OFS_COUNT_STATE = 3'h4;
   localparam logic [2:0] OFS_CLEAR = 3'h5;
   // ===================================================
   // field positions
   localparam int EN_BIT = 0;
   localparam int PERIOD_LSB = 1;
   localparam int WINDOW_LSB = 0;
   localparam int CLKSEL_LSB = 4;
   localparam int ARMED_BIT = 2;
   localparam int COUNT_LSB = 3;
   // ===================================================
   // reset values and codes
   localparam logic [4:0] PERIOD_ALL_ONES = 5'h1F;
   localparam logic [4:0] PERIOD_DEFAULT = 5'h0B;
   localparam logic [2:0] CLKSEL_ALL_ONES = 3'h7;
   localparam logic [2:0] CLKSEL_MFOSC = 3'h1;
   localparam logic [2:0] WINDOW_ALL_ONES = 3'h7;
   localparam logic [7:0] CLEAR_KEY = 8'h5A;
   // ===================================================
   // count clock: 31.25 kHz from 20 MHz
   localparam int SYS_HZ = 20000000;
   localparam int TICK_HZ = 31250;
   localparam int TICK_DIV = SYS_HZ / TICK_HZ;
endpackage : wdt_pkg

// ---- rtl/tick_divider.sv ----
// Purpose: one-cycle enable pulse at the watchdog count rate
// Assumes: single clock, synchronous active-high reset
// Notes: pulse only while run is high; restarts from zero when stopped
`timescale 1ns/1ps
module tick_divider #(
   parameter int DIV = 640
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic run,
   output logic tick
);
   initial begin
      if (DIV < 2) $error("tick_divider: DIV must be at least 2");
   end
   logic [15:0] cnt_r;
   // ===================================================
   // divider
   always_ff @(posedge clk_sys) begin
      if (rst || !run) begin
         cnt_r <= 16'h0000;
         tick <= 1'b0;
      end else if (cnt_r == 16'(DIV - 1)) begin
         cnt_r <= 16'h0000;
         tick <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 16'h0001;
         tick <= 1'b0;
      end
   end
endmodule : tick_divider

// ---- rtl/watchdog_counter_readback.sv ----
// Purpose: windowed watchdog with software readback of its live counters
// Assumes: byte register port, read data valid one cycle after read strobe
// Notes: configuration codes arrive as static inputs sampled one cycle after reset release
// Notes on behaviour
// - an 18-bit prescale count spans low byte, high byte, timer-value bits 1:0
// - low byte returns prescale bits 7:0, read-only, zero after reset
// - high byte returns prescale bits 15:8, read-only, zero after reset
// - timer-value bits 1:0 return prescale bits 17:16, read-only, zero after reset
// - timer-value bits 6:3 show the watchdog count, read-only, zero after reset
// - timer-value bit 2 is one while armed, zero otherwise
// - timer-value bit 7 always reads zero
// - window select closes the period in eighths; 111 none, 000 leaves one eighth
// - count clock select 001 picks the 31.25 kHz oscillator; others reserved
// - period field resets to 01011 when config code is all ones, else config
`timescale 1ns/1ps
module watchdog_counter_readback
   import wdt_pkg::*;
#(
   parameter int PRESCALE_W = 18,
   parameter int COUNT_W = 4
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [7:0] rdata,
   input wire logic [4:0] config_period_code,
   input wire logic [2:0] config_clock_code,
   input wire logic [2:0] config_window_code,
   output logic watchdog_reset,
   output logic window_violation
);
   import wdt_pkg::*;
   initial begin
      if (PRESCALE_W != 18) $error("prescale width must be 18");
      if (COUNT_W != 4) $error("count field must be 4 bits");
   end
   // ===================================================
   // control registers
   logic software_watchdog_enable_r;
   logic [4:0] period_select_r;
   logic [2:0] count_clock_select_r;
   logic [2:0] window_select_r;
   logic period_lock_r, clock_lock_r, window_lock_r;
   logic rst_d_r;
   logic wr_ctl0, wr_ctl1, wr_clear;
   assign wr_ctl0 = wr_stb && addr == OFS_CONTROL_ZERO;
   assign wr_ctl1 = wr_stb && addr == OFS_CONTROL_ONE;
   assign wr_clear = wr_stb && addr == OFS_CLEAR && wdata == CLEAR_KEY;
   // catch configuration one cycle after reset release
   always_ff @(posedge clk_sys) begin
      if (rst) rst_d_r <= 1'b1;
      else rst_d_r <= 1'b0;
   end
   // period field: default when config is all ones, else locked to config
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         period_select_r <= PERIOD_DEFAULT;
         period_lock_r <= 1'b0;
         software_watchdog_enable_r <= 1'b0;
      end else if (rst_d_r) begin
         period_lock_r <= config_period_code != PERIOD_ALL_ONES;
         period_select_r <= (config_period_code == PERIOD_ALL_ONES) ?
            PERIOD_DEFAULT : config_period_code;
      end else if (wr_ctl0) begin
         software_watchdog_enable_r <= wdata[EN_BIT];
         if (!period_lock_r) period_select_r <= wdata[PERIOD_LSB +: 5];
      end
   end
   // clock and window selects, writable only when config leaves them open
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         count_clock_select_r <= 3'h0;
         window_select_r <= WINDOW_ALL_ONES;
         clock_lock_r <= 1'b0;
         window_lock_r <= 1'b0;
      end else if (rst_d_r) begin
         clock_lock_r <= config_clock_code != CLKSEL_ALL_ONES;
         count_clock_select_r <= (config_clock_code == CLKSEL_ALL_ONES) ?
            3'h0 : config_clock_code;
         window_lock_r <= config_window_code != WINDOW_ALL_ONES;
         window_select_r <= config_window_code;
      end else if (wr_ctl1) begin
         if (!clock_lock_r) count_clock_select_r <= wdata[CLKSEL_LSB +: 3];
         if (!window_lock_r) window_select_r <= wdata[WINDOW_LSB +: 3];
      end
   end
   // ===================================================
   // count clock and counters
   logic clk_ok, armed, tick;
   logic [PRESCALE_W-1:0] prescale_count_r;
   logic [COUNT_W-1:0] watchdog_count_value_r;
   logic [PRESCALE_W:0] period_len;
   logic [PRESCALE_W:0] open_point;
   logic timeout, restart;
   assign clk_ok = count_clock_select_r == CLKSEL_MFOSC;
   assign armed = software_watchdog_enable_r && clk_ok;
   // period of 2^(5+sel) ticks, capped at the prescaler width
   assign period_len = (period_select_r > 5'd12) ? (19'h1 << PRESCALE_W) :
      (19'h1 << (period_select_r + 5'd5));
   // closed part is (7 - window)/8 of the period
   assign open_point = 19'((period_len >> 3) * (3'h7 - window_select_r));
   assign timeout = tick && ({1'b0, prescale_count_r} == period_len - 19'h1);
   assign restart = wr_clear || timeout || !armed;
   tick_divider #(
      .DIV(TICK_DIV)
   ) u_tick (
      .clk_sys(clk_sys),
      .rst(rst),
      .run(armed),
      .tick(tick)
   );
   // live prescaler, cleared on clear, timeout or disarm; writes to the prescale offsets never touch it
   always_ff @(posedge clk_sys) begin
      if (rst || restart) prescale_count_r <= '0;
      else if (tick) prescale_count_r <= prescale_count_r + 1'b1;
   end
   // coarse count: steps each eighth of the period
   always_ff @(posedge clk_sys) begin
      if (rst || restart) watchdog_count_value_r <= '0;
      else if (tick && ({1'b0, prescale_count_r} + 19'h1) % (period_len >> 3) == 19'h0)
         watchdog_count_value_r <= watchdog_count_value_r + 1'b1;
   end
   // ===================================================
   // resets out
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         watchdog_reset <= 1'b0;
         window_violation <= 1'b0;
      end else begin
         watchdog_reset <= timeout || (wr_clear && armed &&
            {1'b0, prescale_count_r} < open_point);
         window_violation <= wr_clear && armed &&
            {1'b0, prescale_count_r} < open_point;
      end
   end
   // ===================================================
   // read port
   logic [7:0] rd_mux;
   always_comb begin
      unique case (addr)
         OFS_CONTROL_ZERO: rd_mux = {2'b00, period_select_r, software_watchdog_enable_r};
         OFS_CONTROL_ONE: rd_mux = {1'b0, count_clock_select_r, 1'b0, window_select_r};
         OFS_PRESCALE_LOW: rd_mux = prescale_count_r[7:0];
         OFS_PRESCALE_HIGH: rd_mux = prescale_count_r[15:8];
         OFS_COUNT_STATE: rd_mux = {1'b0, watchdog_count_value_r, armed,
            prescale_count_r[17:16]};
         default: rd_mux = 8'h00;
      endcase
   end
   always_ff @(posedge clk_sys) begin
      if (rst) rdata <= 8'h00;
      else if (rd_stb) rdata <= rd_mux;
      else rdata <= 8'h00;
   end
endmodule : watchdog_counter_readback

// ---- test/wdt_readback_chk_sva.sv ----
// Purpose: port checker for the watchdog readback block
// Assumes: read data stand only in the cycle after rd_stb
// Notes: bound to every instance of the block
`timescale 1ns/1ps
module wdt_readback_chk
   import wdt_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] rdata,
   input wire logic watchdog_reset,
   input wire logic window_violation
);
   // ==========================================
   // bus sequences
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence rd_s(a);
      rd_stb && addr == a;
   endsequence
   sequence wr_s(a, d);
      wr_stb && addr == a && wdata == d;
   endsequence
   // ==========================================
   // properties
   rd_idle_a: assert property (!$past(rd_stb) |-> rdata == 8'h00)
      else $error("read data not zero outside a read");
   top_bit_a: assert property (rd_s(OFS_COUNT_STATE) |=> !rdata[7])
      else $error("unused top bit read as one");
   unmapped_a: assert property (rd_stb && addr > OFS_CLEAR |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   wd_pulse_a: assert property (watchdog_reset |=> !watchdog_reset)
      else $error("watchdog reset longer than one cycle");
   win_pulse_a: assert property (window_violation |=> !window_violation)
      else $error("window flag longer than one cycle");
   reset_quiet_a: assert property ($fell(rst) |-> rdata == 8'h00 && !watchdog_reset)
      else $error("outputs busy right after reset");
   // two cycles give the clear time to land before the read is taken
   clear_zero_a: assert property (wr_s(OFS_CLEAR, CLEAR_KEY) ##2
      (rd_s(OFS_PRESCALE_HIGH) or rd_s(OFS_COUNT_STATE)) |=> (rdata & 8'hFB) == 8'h00)
      else $error("counters not cleared");
   disarm_zero_a: assert property (wr_s(OFS_CONTROL_ZERO, 8'h00) ##2
      rd_s(OFS_COUNT_STATE) |=> rdata == 8'h00)
      else $error("state not zero after disarm");
endmodule : wdt_readback_chk
bind watchdog_counter_readback wdt_readback_chk u_chk (.clk_sys, .rst, .addr, .wdata,
   .wr_stb, .rd_stb, .rdata, .watchdog_reset, .window_violation);

// ---- test/tb_watchdog_counter_readback.sv ----
// Purpose: register-level bench for the watchdog readback block
// Assumes: config period 00000, clock 001, window 000
// Notes: a timeout is 32 ticks of 640 clocks
`timescale 1ns/1ps
module tb_watchdog_counter_readback;
   import wdt_pkg::*;
   logic clk_sys, rst, wr_stb, rd_stb, watchdog_reset, window_violation;
   logic [2:0] addr;
   logic [7:0] wdata, rdata, rv;
   int error_cnt = 0;
   int n_compared = 0;
   // ==========================================
   // clock and device
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   watchdog_counter_readback DUT (.clk_sys, .rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
      .config_period_code(5'h00), .config_clock_code(3'h1), .config_window_code(3'h0),
      .watchdog_reset, .window_violation);
   // ==========================================
   // tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         error_cnt++;
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk_sys);
      wr_stb <= 1'b0;
   endtask : wr
   // sample 1 ns after the answering edge so the registered data has landed
   task automatic rd(input logic [2:0] a);
      @(posedge clk_sys);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk_sys);
      rd_stb <= 1'b0;
      #1 rv = rdata;
   endtask : rd
   // pulses stand one cycle, so look before every edge
   task automatic waitp(input bit v, input int lim);
      for (int i = 0; i < lim; i++) begin
         #1;
         if ((v ? window_violation : watchdog_reset) === 1'b1) begin
            n_compared++;
            return;
         end
         @(posedge clk_sys);
      end
      chk(8'h00, 8'h01);
      complete_run();
   endtask : waitp
   task automatic complete_run;
      $display("compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : complete_run
   // ==========================================
   // main sequence
   initial begin
      rst = 1'b1;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      addr = 3'h0;
      wdata = 8'h00;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      for (int a = 2; a < 8; a++) begin
         rd(a[2:0]);
         chk(rv, 8'h00);
         wr(a[2:0], 8'hFF);
         rd(a[2:0]);
         chk(rv, 8'h00);
      end
      wr(OFS_CONTROL_ZERO, 8'h01);
      repeat (1300) @(posedge clk_sys);
      rd(OFS_COUNT_STATE);
      chk(rv & 8'h83, 8'h00);
      chk(rv & 8'h04, 8'h04);
      rd(OFS_PRESCALE_LOW);
      chk({7'h00, rv == 8'h00}, 8'h00);
      wr(OFS_CLEAR, CLEAR_KEY);
      waitp(1'b1, 4);
      rd(OFS_PRESCALE_HIGH);
      chk(rv, 8'h00);
      wr(OFS_CONTROL_ZERO, 8'h01);
      waitp(1'b0, 21500);
      wr(OFS_CONTROL_ZERO, 8'h00);
      rd(OFS_COUNT_STATE);
      chk(rv, 8'h00);
      // config codes lock period and clock/window fields against software writes
      wr(OFS_CONTROL_ZERO, 8'h3F);
      rd(OFS_CONTROL_ZERO);
      chk(rv, 8'h01);
      wr(OFS_CONTROL_ONE, 8'h77);
      rd(OFS_CONTROL_ONE);
      chk(rv, 8'h10);
      // about six ticks after arming the count field sits at its second eighth
      repeat (3840) @(posedge clk_sys);
      rd(OFS_COUNT_STATE);
      chk(rv, 8'h0C);
      complete_run();
   end
endmodule : tb_watchdog_counter_readback
